// ===== logic/mdu_unit.sv
/*
  Multiply/divide unit with APB register access.
  Assumes an APB master on pclk; operands and results share six data registers.
*/
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/100ps
module mdu_unit (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // status
  output logic busy
);
  import mdu_pkg::*;

  typedef struct packed {
    logic [MDU_NUM_DATA-1:0][7:0] data;
    mdu_seq_t seq;
    mdu_op_t op;
    logic running;
    logic [MDU_CNT_W-1:0] cnt;
    logic load;
    logic err;
    logic ovf;
    logic [31:0] prdata;
  } mdu_state_t;

  mdu_state_t st;
  mdu_state_t next_st;

  logic access;
  logic wr;
  logic rd;
  logic is_data;
  logic is_status;
  logic [MDU_IDX_W-1:0] idx;
  logic start;
  mdu_op_t start_op;
  logic [31:0] res_lo;
  logic [15:0] res_hi;
  logic calc_ovf;

  // ***************************************
  // apb decode, zero-wait answers
  // ***************************************
  assign access = psel && penable;
  assign wr = access && pwrite;
  assign rd = access && !pwrite;
  assign idx = paddr[MDU_IDX_W+1:2];
  assign is_data = (paddr[11:2] < 10'(MDU_NUM_DATA)) && (paddr[1:0] == 2'h0);
  assign is_status = (paddr == MDU_ADDR_STATUS);
  assign pready = 1'b1;
  assign pslverr = access && !is_data && !is_status;
  assign prdata = st.prdata;
  assign busy = st.running;

  // ***************************************
  // sequence tracker
  // ***************************************
  always_comb begin
    start = 1'b0;
    start_op = OP_DIV32;
    if (wr && is_data && pstrb[0] && !st.running && (idx == 3'h5)) begin
      case (st.seq)
        SEQ_W01234: begin
          start = 1'b1;
          start_op = OP_DIV32;
        end
        SEQ_W014: begin
          start = 1'b1;
          start_op = OP_DIV16;
        end
        SEQ_W041: begin
          start = 1'b1;
          start_op = OP_MUL;
        end
        default: begin
          start = 1'b0;
          start_op = OP_DIV32;
        end
      endcase
    end
  end

  mdu_calc u_calc (
    .pclk(pclk),
    .presetn(presetn),
    .start(start),
    .op(start_op),
    .opa(start_op == OP_DIV32 ? {st.data[3], st.data[2], st.data[1], st.data[0]}
                              : {16'h0000, st.data[1], st.data[0]}),
    .opb({pwdata[7:0], st.data[4]}),
    .res_lo(res_lo),
    .res_hi(res_hi),
    .ovf(calc_ovf)
  );

  // ***************************************
  // next state
  // ***************************************
  always_comb begin
    next_st = st;
    next_st.load = 1'b0;
    // register writes and sequence tracking
    if (wr && is_data && pstrb[0]) begin
      if (st.running) begin
        next_st.err = 1'b1;
      end else begin
        next_st.data[idx] = pwdata[7:0];
        case (st.seq)
          SEQ_W0: begin
            next_st.seq = (idx == 3'h1) ? SEQ_W01 : (idx == 3'h4) ? SEQ_W04 : SEQ_IDLE;
          end
          SEQ_W01: begin
            next_st.seq = (idx == 3'h2) ? SEQ_W012 : (idx == 3'h4) ? SEQ_W014 : SEQ_IDLE;
          end
          SEQ_W012: begin
            next_st.seq = (idx == 3'h3) ? SEQ_W0123 : SEQ_IDLE;
          end
          SEQ_W0123: begin
            next_st.seq = (idx == 3'h4) ? SEQ_W01234 : SEQ_IDLE;
          end
          SEQ_W04: begin
            next_st.seq = (idx == 3'h1) ? SEQ_W041 : SEQ_IDLE;
          end
          default: begin
            next_st.seq = SEQ_IDLE;
          end
        endcase
        if (idx == 3'h0) begin
          next_st.seq = SEQ_W0;
        end
        if (start) begin
          next_st.running = 1'b1;
          next_st.op = start_op;
          next_st.seq = SEQ_IDLE;
          case (start_op)
            OP_DIV32: next_st.cnt = MDU_CNT_W'(MDU_CYC_DIV32 - 1);
            OP_DIV16: next_st.cnt = MDU_CNT_W'(MDU_CYC_DIV16 - 1);
            default: next_st.cnt = MDU_CNT_W'(MDU_CYC_MUL - 1);
          endcase
        end
      end
    end
    // read side effects take place at the access edge
    if (rd && is_data && st.running) begin
      next_st.err = 1'b1;
    end
    if (rd && is_status && st.err && !st.running) begin
      next_st.err = 1'b0;
    end
    // calculation countdown
    if (st.running) begin
      if (st.cnt == '0) begin
        next_st.running = 1'b0;
        next_st.ovf = calc_ovf;
        next_st.data[0] = res_lo[7:0];
        next_st.data[1] = res_lo[15:8];
        next_st.data[2] = res_lo[23:16];
        next_st.data[3] = res_lo[31:24];
        next_st.data[4] = res_hi[7:0];
        next_st.data[5] = res_hi[15:8];
        if (st.op == OP_DIV16) begin
          next_st.data[2] = st.data[2];
          next_st.data[3] = st.data[3];
        end
        if (st.op == OP_MUL) begin
          next_st.data[4] = st.data[4];
          next_st.data[5] = st.data[5];
        end
      end else begin
        next_st.cnt = st.cnt - 1'b1;
      end
      if (access && is_data) begin
        next_st.err = 1'b1;
      end
    end
    // read data fetched at the setup edge from the state the access edge sees
    next_st.prdata = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      if (is_data && !next_st.running) begin
        next_st.prdata = {24'h00_0000, next_st.data[idx]};
      end
      if (is_status) begin
        next_st.prdata = 32'(MDU_STATUS_RESET);
        next_st.prdata[MDU_ERR_BIT] = next_st.err;
        next_st.prdata[MDU_OVF_BIT] = next_st.ovf;
      end
    end
  end

  // ***************************************
  // state register
  // ***************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule : mdu_unit

// ===== logic/mdu_pkg.sv
/*
  Package for the multiply/divide unit: register indices, field positions,
  sequence states and calculation times.
  Assumes a 125 MHz pclk and APB with 32-bit data, one register per word.
*/
package mdu_pkg;

  // ***************************************
  // register map
  // ***************************************
  localparam logic [11:0] MDU_ADDR_DATA0 = 12'h000;
  localparam logic [11:0] MDU_ADDR_STATUS = 12'h018;
  localparam int MDU_NUM_DATA = 6;
  localparam int MDU_IDX_W = 3;
  localparam int MDU_ERR_BIT = 7;
  localparam int MDU_OVF_BIT = 6;
  localparam logic [7:0] MDU_STATUS_RESET = 8'h00;

  // ***************************************
  // calculation times in system clock periods
  // ***************************************
  localparam int MDU_CYC_DIV32 = 17;
  localparam int MDU_CYC_DIV16 = 9;
  localparam int MDU_CYC_MUL = 11;
  localparam int MDU_CNT_W = 5;
  localparam logic [15:0] MDU_PROD_MAX = 16'hFFFF;

  // ***************************************
  // write sequence tracker
  // ***************************************
  typedef enum logic [3:0] {
    SEQ_IDLE = 4'h0,
    SEQ_W0 = 4'h1,
    SEQ_W01 = 4'h3,
    SEQ_W012 = 4'h2,
    SEQ_W0123 = 4'h6,
    SEQ_W01234 = 4'h7,
    SEQ_W014 = 4'h5,
    SEQ_W04 = 4'h4,
    SEQ_W041 = 4'hC
  } mdu_seq_t;

  typedef enum logic [1:0] {
    OP_DIV32 = 2'h0,
    OP_DIV16 = 2'h1,
    OP_MUL = 2'h3
  } mdu_op_t;

endpackage : mdu_pkg

// ===== logic/mdu_calc.sv
/*
  Arithmetic core: computes results from the operands presented at start and registers them.
  Assumes operands are held stable while start is high for one cycle.
*/
`timescale 1ns/100ps
module mdu_calc (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // request
  input wire logic start,
  input wire mdu_pkg::mdu_op_t op,
  input wire logic [31:0] opa,
  input wire logic [15:0] opb,
  // result
  output logic [31:0] res_lo,
  output logic [15:0] res_hi,
  output logic ovf
);
  import mdu_pkg::*;

  typedef struct packed {
    logic [31:0] res_lo;
    logic [15:0] res_hi;
    logic ovf;
  } mdu_calc_state_t;

  mdu_calc_state_t st;
  mdu_calc_state_t next_st;
  logic [31:0] prod;

  // ***************************************
  // result computation
  // ***************************************
  always_comb begin
    next_st = st;
    prod = opa[15:0] * opb;
    if (start) begin
      case (op)
        OP_MUL: begin
          next_st.res_lo = prod;
          next_st.res_hi = 16'h0000;
          next_st.ovf = (prod > {16'h0000, MDU_PROD_MAX});
        end
        default: begin
          if (opb == 16'h0000) begin
            next_st.res_lo = 32'h0000_0000;
            next_st.res_hi = 16'h0000;
            next_st.ovf = 1'b1;
          end else begin
            next_st.res_lo = opa / {16'h0000, opb};
            next_st.res_hi = 16'(opa % {16'h0000, opb});
            next_st.ovf = 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign res_lo = st.res_lo;
  assign res_hi = st.res_hi;
  assign ovf = st.ovf;

endmodule : mdu_calc

// ===== tb/mdu_unit_asserts.sv
/*
  Checker for mdu_unit: port-level timing of the apb slave and the calculation.
  Assumes zero-wait apb and registered read data, bound to every mdu_unit.
*/
`timescale 1ns/100ps
module mdu_unit_asserts (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // status
  input wire logic busy
);
  // ***************************************
  // helper logic
  // ***************************************
  logic [5:0] cnt;
  wire logic acc = psel && penable;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt <= 6'h00;
    else cnt <= busy ? cnt + 6'h01 : 6'h00;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ***************************************
  // assertions
  // ***************************************
  ready_always_a: assert property (pready)
    else $error("pready low");
  start_cause_a: assert property ($rose(busy) |-> $past(acc && pwrite && paddr == 12'h014))
    else $error("busy rose without a data 5 write");
  busy_len_a: assert property ($fell(busy) |-> cnt == 6'h11 || cnt == 6'h09 || cnt == 6'h0B)
    else $error("calculation length wrong");
  busy_min_a: assert property ($rose(busy) |-> busy [*8])
    else $error("calculation too short");
  status_pad_a: assert property (acc && !pwrite && paddr == 12'h018 |-> prdata[5:0] == 6'h00 && prdata[31:8] == 24'h000000)
    else $error("status padding not zero");
  busy_read_a: assert property (acc && !pwrite && busy && paddr < 12'h018 |-> prdata == 32'h00000000)
    else $error("data read while busy returned data");
  unmapped_err_a: assert property (acc && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 12'h018))
    else $error("pslverr wrong");
  read_idle_a: assert property (!(acc && !pwrite) |-> prdata == 32'h00000000)
    else $error("prdata not cleared");
endmodule : mdu_unit_asserts

bind mdu_unit mdu_unit_asserts u_asserts (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .busy(busy));

// ===== tb/mdu_unit_bench.sv
/*
  Bench for mdu_unit: apb tasks and operand sequences with expected results.
  Assumes apb read data valid in the access phase, taken at the ready edge.
*/
`timescale 1ns/100ps
module mdu_unit_bench;
  import mdu_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, q;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, busy, qe;
  int n_mismatch = 0, comparisons = 0;
  always #4 pclk = ~pclk;
  mdu_unit u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .busy(busy));
  // ***************************************
  // tasks
  // ***************************************
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    qe = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : bus
  task automatic run(input mdu_op_t op, input logic [31:0] a, input logic [15:0] b, input bit inj);
    logic [3:0] ix [$];
    logic [7:0] dv [$];
    logic [31:0] p;
    logic [15:0] r;
    logic o;
    int n, cyc;
    n = 0;
    o = (b == 16'h0000);
    if (op == OP_MUL) begin
      ix = '{4'h0, 4'h4, 4'h1, 4'h5};
      dv = '{a[7:0], b[7:0], a[15:8], b[15:8]};
      p = a[15:0] * b;
      r = 16'h0000;
      o = (p > 32'h0000FFFF);
      cyc = MDU_CYC_MUL;
    end else begin
      if (op == OP_DIV16) begin
        a = {16'h0000, a[15:0]};
        ix = '{4'h0, 4'h1, 4'h4, 4'h5};
        dv = '{a[7:0], a[15:8], b[7:0], b[15:8]};
      end else begin
        ix = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5};
        dv = '{a[7:0], a[15:8], a[23:16], a[31:24], b[7:0], b[15:8]};
      end
      p = o ? 32'h00000000 : a / b;
      r = o ? 16'h0000 : 16'(a % b);
      cyc = (op == OP_DIV16) ? MDU_CYC_DIV16 : MDU_CYC_DIV32;
    end
    foreach (ix[i]) begin
      bus(1'b1, {6'h00, ix[i], 2'b00}, dv[i]);
      if (i == 1) bus(1'b0, MDU_ADDR_STATUS, 8'h00);
    end
    while (busy === 1'b1 && n < 40) begin
      n++;
      if (inj && n == 3) begin
        bus(1'b0, MDU_ADDR_DATA0, 8'h00);
        chk("busy read", 32'h00000000, q);
        n += 2;
      end else begin
        @(posedge pclk);
      end
    end
    chk("cycles", cyc, n);
    bus(1'b0, MDU_ADDR_STATUS, 8'h00);
    chk("status", {24'h000000, inj, o, 6'h00}, q);
    bus(1'b0, MDU_ADDR_STATUS, 8'h00);
    chk("status again", {24'h000000, 1'b0, o, 6'h00}, q);
    if (op == OP_MUL) ix = '{4'h0, 4'h1, 4'h2, 4'h3};
    foreach (ix[i]) begin
      bus(1'b0, {6'h00, ix[i], 2'b00}, 8'h00);
      chk("result", {24'h000000, ix[i] < 4 ? p[8*ix[i]+:8] : r[8*(ix[i]-4)+:8]}, q);
    end
    $display("test op %0d done", op);
  endtask : run
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim
  // ***************************************
  // tests
  // ***************************************
  initial begin
    #200000;
    n_mismatch++;
    $display("unexpected watchdog exp finished got timeout");
    end_sim;
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    bus(1'b0, MDU_ADDR_STATUS, 8'h00);
    chk("status reset", {24'h000000, MDU_STATUS_RESET}, q);
    bus(1'b1, MDU_ADDR_STATUS, 8'hFF);
    bus(1'b0, MDU_ADDR_STATUS, 8'h00);
    chk("status write", 32'h00000000, q);
    bus(1'b0, 12'h01C, 8'h00);
    chk("pslverr", 32'h00000001, {31'h0, qe});
    bus(1'b1, 12'h000, 8'h11);
    bus(1'b1, 12'h004, 8'h22);
    bus(1'b1, 12'h014, 8'h33);
    chk("no start", 32'h00000000, {31'h0, busy});
    bus(1'b0, 12'h004, 8'h00);
    chk("data rw", 32'h00000022, q);
    $display("test access done");
    run(OP_MUL, 32'h000000FF, 16'h0101, 1'b0);
    run(OP_MUL, 32'h00001234, 16'h0100, 1'b0);
    bus(1'b1, MDU_ADDR_DATA0, 8'h55);
    bus(1'b1, 12'h010, 8'h66);
    run(OP_DIV16, 32'h0000ABCD, 16'h0012, 1'b0);
    run(OP_DIV16, 32'h00001234, 16'h0000, 1'b1);
    run(OP_DIV32, 32'h12345678, 16'h0ABC, 1'b1);
    run(OP_DIV32, 32'hFFFFFFFF, 16'h0001, 1'b0);
    end_sim;
  end
endmodule : mdu_unit_bench
